//--- hdl/rfxr_fmt_sel.v
// Arithmetic-type label selection for the reinterpret stage.
`timescale 1ns/1ps
`default_nettype none
`include "rfxr_regs.vh"

module rfxr_fmt_sel (
  input wire force_type,
  input wire [1:0] sel_type,
  input wire [1:0] in_type,
  output reg [1:0] out_type,
  output wire out_signed,
  output wire out_float,
  output wire type_bad
);

  // The label follows the selection only while forcing is on.
  always @* begin
    if (force_type) begin
      out_type = sel_type;
    end else begin
      out_type = in_type;
    end
  end

  assign out_signed = (out_type == `RFXR_TYPE_SIGNED);
  assign out_float = (out_type == `RFXR_TYPE_FLOAT);
  // Code 3 names no type; it is reported only when forced from sel_type, and the label is passed on as written.
  assign type_bad = force_type && (sel_type != `RFXR_TYPE_UNSIGNED) &&
                    (sel_type != `RFXR_TYPE_SIGNED) && (sel_type != `RFXR_TYPE_FLOAT);

endmodule

`default_nettype wire

//--- hdl/rfxr_point_sel.v
// Binary-point label selection and legality check for the reinterpret stage.
`timescale 1ns/1ps
`default_nettype none

module rfxr_point_sel #(
  parameter DATA_W = 16,
  parameter POINT_W = 5
) (
  input wire force_point,
  input wire [POINT_W-1:0] sel_point,
  input wire [POINT_W-1:0] in_point,
  output wire [POINT_W-1:0] out_point,
  output wire point_bad
);

  // POINT_W must be wide enough to hold DATA_W itself, or the limit wraps.
  localparam [POINT_W-1:0] MAX_POINT = DATA_W[POINT_W-1:0];

  // Moving the point only rescales the value; the bits are not touched.
  assign out_point = force_point ? sel_point : in_point;
  // Legal positions run from zero to the word width inclusive.
  assign point_bad = force_point && (sel_point > MAX_POINT);

endmodule

`default_nettype wire

//--- hdl/rfxr_regs.vh
// Register offsets, field positions, codes and reset values of the reinterpret stage.
`ifndef RFXR_REGS_VH
`define RFXR_REGS_VH

`define RFXR_ADDR_W 12

`define RFXR_OFF_CTRL 12'h000
`define RFXR_OFF_OUT_TYPE 12'h004
`define RFXR_OFF_OUT_POINT 12'h008
`define RFXR_OFF_STATUS 12'h00C
`define RFXR_OFF_INFO 12'h010
`define RFXR_OFF_DATA 12'h014
`define RFXR_OFF_ERR 12'h018

`define RFXR_CTRL_FORCE_TYPE 0
`define RFXR_CTRL_FORCE_POINT 1

`define RFXR_TYPE_UNSIGNED 2'h0
`define RFXR_TYPE_SIGNED 2'h1
`define RFXR_TYPE_FLOAT 2'h2

`define RFXR_ST_TYPE_LSB 0
`define RFXR_ST_POINT_BAD 2
`define RFXR_ST_TYPE_BAD 3
`define RFXR_ST_POINT_LSB 8

`define RFXR_INFO_WIDTH_LSB 0
`define RFXR_INFO_PW_LSB 16

`define RFXR_ERR_POINT 0
`define RFXR_ERR_TYPE 1

`define RFXR_CTRL_RST 2'h0
`define RFXR_TYPE_RST 2'h0
`define RFXR_ERR_RST 2'h0

`endif

//--- hdl/rfxr_top.v
// Type reinterpret stage: bit-exact data pass with APB-programmed format labels.
`timescale 1ns/1ps
`default_nettype none
`include "rfxr_regs.vh"

module rfxr_top #(
  parameter DATA_W = 16,
  parameter POINT_W = 5
) (
  input wire SYS_CLK,
  input wire SRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`RFXR_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire [DATA_W-1:0] DATA_IN,
  input wire [1:0] IN_TYPE,
  input wire [POINT_W-1:0] IN_POINT,
  output wire [DATA_W-1:0] DATA_OUT,
  output wire [1:0] OUT_TYPE,
  output wire OUT_SIGNED,
  output wire OUT_FLOAT,
  output wire [POINT_W-1:0] OUT_POINT,
  output wire POINT_BAD,
  output wire TYPE_BAD
);

  // Both widths are small figures; the part-selects cut them to their fields on purpose.
  localparam [15:0] WIDTH_CODE = DATA_W[15:0];
  localparam [7:0] PW_CODE = POINT_W[7:0];

  // Configuration written by software.
  reg [1:0] ctrl_r;
  reg [1:0] ctrl_nxt;
  reg [1:0] type_sel_r;
  reg [1:0] type_sel_nxt;
  reg [POINT_W-1:0] point_sel_r;
  reg [POINT_W-1:0] point_sel_nxt;
  // Sticky record of illegal settings seen while they were in force.
  reg [1:0] err_r;
  reg [1:0] err_nxt;

  wire acc_phase;
  wire wr_en;
  wire rd_en;
  wire addr_hit;
  wire [31:0] data_view;

  // ---------------------------------------------------------------
  // Data path.
  // ---------------------------------------------------------------

  // The word is never registered or rebuilt: the labels alone change, so a
  // signed pattern such as 111000 read as -2.0 leaves as 56 when relabelled.
  assign DATA_OUT = DATA_IN;

  rfxr_fmt_sel u_fmt_sel (
    .force_type(ctrl_r[`RFXR_CTRL_FORCE_TYPE]),
    .sel_type(type_sel_r),
    .in_type(IN_TYPE),
    .out_type(OUT_TYPE),
    .out_signed(OUT_SIGNED),
    .out_float(OUT_FLOAT),
    .type_bad(TYPE_BAD)
  );

  rfxr_point_sel #(
    .DATA_W(DATA_W),
    .POINT_W(POINT_W)
  ) u_point_sel (
    .force_point(ctrl_r[`RFXR_CTRL_FORCE_POINT]),
    .sel_point(point_sel_r),
    .in_point(IN_POINT),
    .out_point(OUT_POINT),
    .point_bad(POINT_BAD)
  );

  // ---------------------------------------------------------------
  // Read view of the live word, fitted to the 32-bit bus.
  // ---------------------------------------------------------------

  generate
    if (DATA_W >= 32) begin : g_view_wide
      // Wider words show only their low 32 bits to software.
      assign data_view = DATA_OUT[31:0];
    end else begin : g_view_narrow
      assign data_view = {{(32-DATA_W){1'b0}}, DATA_OUT};
    end
  endgenerate

  // ---------------------------------------------------------------
  // APB slave.
  // ---------------------------------------------------------------

  // The slave never stretches a transfer: every access completes in the
  // first access-phase cycle.
  assign PREADY = 1'b1;
  assign acc_phase = PSEL && PENABLE;
  assign wr_en = acc_phase && PWRITE;
  assign rd_en = PSEL && !PWRITE;

  assign addr_hit = (PADDR == `RFXR_OFF_CTRL) ||
                    (PADDR == `RFXR_OFF_OUT_TYPE) ||
                    (PADDR == `RFXR_OFF_OUT_POINT) ||
                    (PADDR == `RFXR_OFF_STATUS) ||
                    (PADDR == `RFXR_OFF_INFO) ||
                    (PADDR == `RFXR_OFF_DATA) ||
                    (PADDR == `RFXR_OFF_ERR);

  // An unmapped address answers with an error; the access has no effect.
  assign PSLVERR = acc_phase && !addr_hit;

  // Next values of the writable registers. Only byte lane 0 carries fields.
  always @* begin
    ctrl_nxt = ctrl_r;
    type_sel_nxt = type_sel_r;
    point_sel_nxt = point_sel_r;
    if (wr_en && PSTRB[0]) begin
      case (PADDR)
        `RFXR_OFF_CTRL: begin
          ctrl_nxt = PWDATA[1:0];
        end
        `RFXR_OFF_OUT_TYPE: begin
          type_sel_nxt = PWDATA[1:0];
        end
        `RFXR_OFF_OUT_POINT: begin
          // The value is stored as written; an illegal one is flagged, not clipped.
          point_sel_nxt = PWDATA[POINT_W-1:0];
        end
        default: begin
          ctrl_nxt = ctrl_r;
        end
      endcase
    end
  end

  // Error flags clear by writing one; an illegal setting present in the
  // same cycle keeps its flag set, so the event is never lost.
  always @* begin
    err_nxt = err_r;
    if (wr_en && PSTRB[0] && (PADDR == `RFXR_OFF_ERR)) begin
      err_nxt = err_r & ~PWDATA[1:0];
    end
    if (POINT_BAD) begin
      err_nxt[`RFXR_ERR_POINT] = 1'b1;
    end
    if (TYPE_BAD) begin
      err_nxt[`RFXR_ERR_TYPE] = 1'b1;
    end
  end

  // Only configuration and the error flags are clocked; the data path stays combinational.
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl_r <= `RFXR_CTRL_RST;
      type_sel_r <= `RFXR_TYPE_RST;
      point_sel_r <= {POINT_W{1'b0}};
      err_r <= `RFXR_ERR_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      type_sel_r <= type_sel_nxt;
      point_sel_r <= point_sel_nxt;
      err_r <= err_nxt;
    end
  end

  // Read mux. Bits not named by a field read as zero.
  always @* begin
    PRDATA = 32'h0000_0000;
    if (rd_en) begin
      case (PADDR)
        `RFXR_OFF_CTRL: begin
          PRDATA[1:0] = ctrl_r;
        end
        `RFXR_OFF_OUT_TYPE: begin
          PRDATA[1:0] = type_sel_r;
        end
        `RFXR_OFF_OUT_POINT: begin
          PRDATA[POINT_W-1:0] = point_sel_r;
        end
        `RFXR_OFF_STATUS: begin
          PRDATA[`RFXR_ST_TYPE_LSB +: 2] = OUT_TYPE;
          PRDATA[`RFXR_ST_POINT_BAD] = POINT_BAD;
          PRDATA[`RFXR_ST_TYPE_BAD] = TYPE_BAD;
          PRDATA[`RFXR_ST_POINT_LSB +: POINT_W] = OUT_POINT;
        end
        `RFXR_OFF_INFO: begin
          // Output width equals input width, so one figure describes both.
          PRDATA[`RFXR_INFO_WIDTH_LSB +: 16] = WIDTH_CODE;
          PRDATA[`RFXR_INFO_PW_LSB +: 8] = PW_CODE;
        end
        `RFXR_OFF_DATA: begin
          PRDATA = data_view;
        end
        `RFXR_OFF_ERR: begin
          PRDATA[1:0] = err_r;
        end
        default: begin
          PRDATA = 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- test/rfxr_top_asserts.sv
// Port-level checker for the reinterpret stage.
`timescale 1ns/1ps
`default_nettype none
module rfxr_checker #(
  parameter DATA_W = 16,
  parameter POINT_W = 5
) (
  input wire SYS_CLK,
  input wire SRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire PSLVERR,
  input wire [DATA_W-1:0] DATA_IN,
  input wire [1:0] IN_TYPE,
  input wire [POINT_W-1:0] IN_POINT,
  input wire [DATA_W-1:0] DATA_OUT,
  input wire [1:0] OUT_TYPE,
  input wire OUT_SIGNED,
  input wire OUT_FLOAT,
  input wire [POINT_W-1:0] OUT_POINT,
  input wire POINT_BAD,
  input wire TYPE_BAD
);
  wire wr_acc = PSEL && PENABLE && PWRITE;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  data_pass_a: assert property (DATA_OUT == DATA_IN)
    else $error("data word altered");
  data_now_a: assert property ($changed(DATA_IN) |-> $changed(DATA_OUT))
    else $error("data output lags input");
  sign_flag_a: assert property (OUT_SIGNED == (OUT_TYPE == 2'h1))
    else $error("signed flag wrong");
  float_flag_a: assert property (OUT_FLOAT == (OUT_TYPE == 2'h2))
    else $error("float flag wrong");
  // Labels may only move after a register write, an input label change or reset.
  type_hold_a: assert property ($changed(OUT_TYPE) |->
    $changed(IN_TYPE) || $past(wr_acc) || $past(SRST))
    else $error("type label moved alone");
  point_hold_a: assert property ($changed(OUT_POINT) |->
    $changed(IN_POINT) || $past(wr_acc) || $past(SRST))
    else $error("point label moved alone");
  point_bad_a: assert property (POINT_BAD |-> OUT_POINT > DATA_W)
    else $error("legal point flagged");
  type_bad_a: assert property (TYPE_BAD |-> OUT_TYPE == 2'h3)
    else $error("legal type flagged");
  bus_err_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access");
  cover property (TYPE_BAD);
  cover property (POINT_BAD);
  cover property (OUT_FLOAT);
endmodule
bind rfxr_top rfxr_checker #(.DATA_W(DATA_W), .POINT_W(POINT_W)) u_chk (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PSLVERR(PSLVERR), .DATA_IN(DATA_IN), .IN_TYPE(IN_TYPE),
  .IN_POINT(IN_POINT), .DATA_OUT(DATA_OUT), .OUT_TYPE(OUT_TYPE),
  .OUT_SIGNED(OUT_SIGNED), .OUT_FLOAT(OUT_FLOAT), .OUT_POINT(OUT_POINT),
  .POINT_BAD(POINT_BAD), .TYPE_BAD(TYPE_BAD)
);
`default_nettype wire

//--- test/rfxr_top_tb.sv
// Self-checking bench for the reinterpret stage.
`timescale 1ns/1ps
`default_nettype none
`include "rfxr_regs.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module rfxr_top_tb;
  typedef struct packed {
    logic [1:0] ctrl, st; logic [4:0] sp; logic [15:0] d; logic [1:0] it;
    logic [4:0] ip; logic [1:0] et; logic [4:0] ep; logic pb, tb;
  } rfxr_row_t;
  rfxr_row_t rows [7] = '{
    '{2'h0, 2'h3, 5'h1F, 16'h1234, 2'h1, 5'h02, 2'h1, 5'h02, 1'h0, 1'h0},
    '{2'h3, 2'h0, 5'h00, 16'h0038, 2'h1, 5'h02, 2'h0, 5'h00, 1'h0, 1'h0},
    '{2'h1, 2'h1, 5'h00, 16'hFFFF, 2'h0, 5'h04, 2'h1, 5'h04, 1'h0, 1'h0},
    '{2'h1, 2'h2, 5'h00, 16'hA5A5, 2'h1, 5'h03, 2'h2, 5'h03, 1'h0, 1'h0},
    '{2'h2, 2'h0, 5'h10, 16'h8001, 2'h2, 5'h00, 2'h2, 5'h10, 1'h0, 1'h0},
    '{2'h2, 2'h0, 5'h11, 16'h0001, 2'h0, 5'h00, 2'h0, 5'h11, 1'h1, 1'h0},
    '{2'h1, 2'h3, 5'h00, 16'h7FFF, 2'h0, 5'h00, 2'h3, 5'h00, 1'h0, 1'h1}};
  logic SYS_CLK = 1'h0, SRST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rdat;
  logic [3:0] PSTRB = 4'hF;
  logic PREADY, PSLVERR, rerr, POINT_BAD, TYPE_BAD, OUT_SIGNED, OUT_FLOAT;
  logic [15:0] DATA_IN = '0, DATA_OUT;
  logic [1:0] IN_TYPE = '0, OUT_TYPE;
  logic [4:0] IN_POINT = '0, OUT_POINT;
  int n_errors = 0, checks_done = 0, cyc = 0;
  rfxr_top #(.DATA_W(16), .POINT_W(5)) u_dut (.SYS_CLK(SYS_CLK), .SRST(SRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DATA_IN(DATA_IN), .IN_TYPE(IN_TYPE), .IN_POINT(IN_POINT), .DATA_OUT(DATA_OUT),
    .OUT_TYPE(OUT_TYPE), .OUT_SIGNED(OUT_SIGNED), .OUT_FLOAT(OUT_FLOAT),
    .OUT_POINT(OUT_POINT), .POINT_BAD(POINT_BAD), .TYPE_BAD(TYPE_BAD));
  initial forever #5 SYS_CLK = ~SYS_CLK;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge SYS_CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'h1;
    do @(posedge SYS_CLK); while (PREADY !== 1'h1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge SYS_CLK);
    SRST <= 1'h0;
    foreach (rows[i]) begin
      apb(1'h1, `RFXR_OFF_OUT_TYPE, {30'h0, rows[i].st});
      apb(1'h1, `RFXR_OFF_OUT_POINT, {27'h0, rows[i].sp});
      apb(1'h1, `RFXR_OFF_CTRL, {30'h0, rows[i].ctrl});
      @(posedge SYS_CLK);
      DATA_IN <= rows[i].d;
      IN_TYPE <= rows[i].it;
      IN_POINT <= rows[i].ip;
      @(negedge SYS_CLK);
      `CHK("data", rows[i].d, DATA_OUT)
      `CHK("type", rows[i].et, OUT_TYPE)
      `CHK("sign", rows[i].et == 2'h1, OUT_SIGNED)
      `CHK("float", rows[i].et == 2'h2, OUT_FLOAT)
      `CHK("point", rows[i].ep, OUT_POINT)
      `CHK("flags", {rows[i].pb, rows[i].tb}, {POINT_BAD, TYPE_BAD})
      apb(1'h0, `RFXR_OFF_DATA, '0);
      `CHK("live", {16'h0, rows[i].d}, rdat)
    end
    // Both flags are cleared; the point one goes, the type one stays while code 3 is forced.
    apb(1'h1, `RFXR_OFF_ERR, 32'h0000_0003);
    apb(1'h0, `RFXR_OFF_ERR, '0);
    `CHK("err", 32'h0000_0002, rdat)
    apb(1'h0, 12'h01C, '0);
    `CHK("unmapped", 33'h0_0000_0001, {rdat, rerr})
    apb(1'h1, `RFXR_OFF_INFO, 32'hFFFF_FFFF);
    apb(1'h0, `RFXR_OFF_INFO, '0);
    `CHK("info", 32'h0005_0010, rdat)
    @(posedge SYS_CLK);
    SRST <= 1'h1;
    @(posedge SYS_CLK);
    SRST <= 1'h0;
    apb(1'h0, `RFXR_OFF_CTRL, '0);
    `CHK("ctrl", 32'h0000_0000, rdat)
    `CHK("reset type", 2'h0, OUT_TYPE)
    apb(1'h0, `RFXR_OFF_ERR, '0);
    `CHK("reset err", 32'h0000_0000, rdat)
    give_verdict();
  end
endmodule
`default_nettype wire
